// >>> src/acr_pkg.sv
package acr_pkg;

  // Oversampling per bit
  localparam int unsigned SAMPLES_NORMAL = 16;
  localparam int unsigned SAMPLES_DOUBLE = 8;

  // First centre sample (start qualification and bit voting)
  localparam logic [3:0] VOTE_FIRST_NORMAL = 4'h8;
  localparam logic [3:0] VOTE_FIRST_DOUBLE = 4'h4;

  // Data plus parity length limits
  localparam int unsigned BITS_MIN = 5;
  localparam int unsigned BITS_MAX = 10;
  localparam logic [3:0]  BITS_RESET = 4'h8;

  // Receive buffer depth
  localparam int unsigned FIFO_DEPTH = 8;

  // Recovery states
  typedef enum logic [1:0] {
    ACR_IDLE  = 2'b00,
    ACR_START = 2'b01,
    ACR_DATA  = 2'b10,
    ACR_STOP  = 2'b11
  } acr_state_t;

endpackage : acr_pkg

// >>> src/acr_fifo.sv
`timescale 1ns/10ps
// Small synchronous FIFO, valid/ready on both sides
module acr_fifo #(
  parameter int unsigned WIDTH = 11,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("acr_fifo: DEPTH must be a power of two of at least 2");
    end
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  // Honest full and empty from the fill count
  assign in_ready  = (cnt_q != AW'(0) + (AW+1)'(DEPTH)) ;
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready && !flush;
  assign pop       = out_valid && out_ready && !flush;

  // Pointer and count update; flush empties the buffer
  always_comb begin
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (flush) begin
      wr_d  = '0;
      rd_d  = '0;
      cnt_d = '0;
    end else begin
      if (push) begin
        wr_d = wr_q + AW'(1);
      end
      if (pop) begin
        rd_d = rd_q + AW'(1);
      end
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Pointer registers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage has no reset; only written words are ever read
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

endmodule : acr_fifo

// >>> src/acr_rx.sv
`timescale 1ns/10ps
// What this block does
// [RL1] Sixteen samples per bit, eight in double speed
// [RL2] Double speed when double_speed_select is one
// [RL3] Falling edge starts detection, first low is one
// [RL4] Start judged on samples 8-10, or 4-6
// [RL5] Two high qualifiers: discard, watch for edge
// [RL6] Realign bit timing on every valid start
// [RL7] Per-bit state counter: sixteen or eight states
// [RL8] Bit value is majority of centre three
// [RL9] Recover through first stop bit; ignore others
// [RL10] Voted low stop bit sets frame error
// [RL11] New start accepted right after stop voting
// [RL12] Transmitter keeps rate within length tolerance
// [RL13] Normal mode, eight bits: two percent each
// [RL14] Double speed, eight bits: one and half percent
// [RL15] Double speed halves per-bit divisor to eight
// [RL16] Frame error stored with data in buffer
// [RL17] Receive line passes two-stage synchroniser
// [RL18] Advance on sample tick; disable restarts idle
module acr_rx #(
  parameter int unsigned DATA_BITS_MAX = acr_pkg::BITS_MAX,
  parameter int unsigned DEPTH         = acr_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     arst_n,
  // Control
  input  wire logic                     rx_enable,
  input  wire logic                     double_speed_select,
  input  wire logic [3:0]               frame_bits,
  input  wire logic                     sample_tick,
  // Serial line
  input  wire logic                     rxd,
  // Received frames
  output logic                          frame_valid,
  input  wire logic                     frame_ready,
  output logic [DATA_BITS_MAX-1:0]      frame_data,
  output logic                          frame_error_flag,
  // Status
  output logic                          rx_busy,
  output logic                          overrun
);

  localparam int unsigned W = DATA_BITS_MAX;

  initial begin
    if (W < acr_pkg::BITS_MIN || W > acr_pkg::BITS_MAX) begin
      $error("acr_rx: DATA_BITS_MAX must lie between 5 and 10");
    end
  end

  // Majority of three samples
  function automatic logic vote3(input logic [2:0] s);
    vote3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : vote3

  // Two-flop synchroniser, first stage read only by second
  logic sync1_q, sync2_q, line_q;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= rxd; // RL17
      sync2_q <= sync1_q; // RL17
    end
  end

  // Recovery state
  acr_pkg::acr_state_t st_q, st_d;
  logic [3:0]   smp_q, smp_d;
  logic [2:0]   win_q, win_d;
  logic [3:0]   bit_q, bit_d;
  logic [W-1:0] sh_q, sh_d;
  logic         dbl_q, dbl_d;
  logic         line_d;
  logic         push;
  logic         push_fe;
  logic [3:0]   last_smp, vote_first, nbits;
  logic         bit_vote;
  logic         fifo_ready, fifo_valid;
  logic [W:0]   fifo_out;
  logic         ovr_q, ovr_d;

  // Mode is latched per frame so a mid-frame change cannot tear timing
  assign last_smp   = dbl_q ? 4'(acr_pkg::SAMPLES_DOUBLE - 1) : 4'(acr_pkg::SAMPLES_NORMAL - 1); // RL1 RL7 RL15
  // Centre voting keeps the widest margin for rate error either way
  assign vote_first = dbl_q ? acr_pkg::VOTE_FIRST_DOUBLE : acr_pkg::VOTE_FIRST_NORMAL; // RL4 RL13 RL14
  assign nbits      = (frame_bits < 4'(acr_pkg::BITS_MIN)) ? 4'(acr_pkg::BITS_MIN) :
                      (frame_bits > 4'(W)) ? 4'(W) : frame_bits;
  assign bit_vote   = vote3({win_q[1:0], line_q}); // RL8

  // Next-state logic for clock and data recovery
  always_comb begin
    st_d    = st_q;
    smp_d   = smp_q;
    win_d   = win_q;
    bit_d   = bit_q;
    sh_d    = sh_q;
    dbl_d   = dbl_q;
    line_d  = line_q;
    push    = 1'b0;
    push_fe = 1'b0;
    ovr_d   = ovr_q;
    if (frame_ready && fifo_valid && fv_q) begin
      ovr_d = 1'b0;
    end
    if (!rx_enable) begin
      st_d  = acr_pkg::ACR_IDLE; // RL18
      ovr_d = 1'b0;
      line_d = 1'b1;
    end else if (sample_tick) begin // RL18
      line_d = sync2_q;
      // Window holds the three previous samples; the vote uses the last two; current is line_q
      win_d  = {win_q[1:0], line_q};
      smp_d  = smp_q + 4'h1;
      case (st_q)
        acr_pkg::ACR_IDLE: begin
          smp_d = 4'h1;
          if (line_q && !sync2_q) begin // RL3
            st_d  = acr_pkg::ACR_START;
            dbl_d = double_speed_select; // RL2
          end
        end
        acr_pkg::ACR_START: begin
          // Third qualifier sample is the one now on line_q
          if (smp_q == vote_first + 4'h2) begin
            if (bit_vote) begin
              st_d = acr_pkg::ACR_IDLE; // RL5
            end
          end
          // Last start sample wraps to zero in normal mode, so one compare serves both
          if (smp_q == last_smp + 4'h1) begin
            // Counter now aligned to the start bit
            smp_d = 4'h0; // RL6
            bit_d = 4'h0;
            if (st_d == acr_pkg::ACR_START) begin
              st_d = acr_pkg::ACR_DATA;
            end
          end
        end
        acr_pkg::ACR_DATA: begin
          if (smp_q == vote_first + 4'h1) begin
            sh_d = {bit_vote, sh_q[W-1:1]}; // RL8
          end
          if (smp_q == last_smp) begin // RL7
            smp_d = 4'h0;
            bit_d = bit_q + 4'h1;
            if (bit_q + 4'h1 == nbits) begin
              st_d = acr_pkg::ACR_STOP;
            end
          end
        end
        acr_pkg::ACR_STOP: begin
          // Only the first stop bit is examined
          if (smp_q == vote_first + 4'h1) begin // RL9
            push    = 1'b1;
            push_fe = ~bit_vote; // RL10
            if (!fifo_ready) begin
              ovr_d = 1'b1;
            end
            st_d = acr_pkg::ACR_IDLE; // RL11
          end
        end
        default: begin
          st_d = acr_pkg::ACR_IDLE;
        end
      endcase
    end
  end

  // Recovery registers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_q   <= acr_pkg::ACR_IDLE;
      smp_q  <= 4'h0;
      win_q  <= 3'h7;
      bit_q  <= 4'h0;
      sh_q   <= '0;
      dbl_q  <= 1'b0;
      line_q <= 1'b1;
      ovr_q  <= 1'b0;
    end else begin
      st_q   <= st_d;
      smp_q  <= smp_d;
      win_q  <= win_d;
      bit_q  <= bit_d;
      sh_q   <= sh_d;
      dbl_q  <= dbl_d;
      line_q <= line_d;
      ovr_q  <= ovr_d;
    end
  end

  // Right-justify shorter frames, upper bits zero
  logic [W-1:0] frame_word;
  logic         fv_q;
  always_comb begin
    frame_word = sh_q >> (W - 32'(nbits));
  end

  // Frame and its error travel together; full buffer drops frame
  acr_fifo #(
    .WIDTH (W + 1),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .flush     (!rx_enable),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   ({push_fe, frame_word}), // RL16
    .out_valid (fifo_valid),
    .out_ready (frame_ready && fv_q),
    .out_data  (fifo_out)
  );

  // Registered outputs; a skid register would cost area, so outputs
  // mirror the buffer head one cycle late and pop follows frame_ready
  logic [W-1:0] fd_q;
  logic         fe_q, busy_q;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      fv_q   <= 1'b0;
      fd_q   <= '0;
      fe_q   <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      fv_q   <= fifo_valid && !(frame_ready && fv_q);
      fd_q   <= fifo_out[W-1:0];
      fe_q   <= fifo_out[W]; // RL16
      busy_q <= (st_d != acr_pkg::ACR_IDLE);
    end
  end

  assign frame_valid      = fv_q;
  assign frame_data       = fd_q;
  assign frame_error_flag = fe_q;
  assign rx_busy          = busy_q;
  assign overrun          = ovr_q;

endmodule : acr_rx

// >>> testbench/acr_sva.sv
`timescale 1ns/10ps
// Port checks on the receiver
module acr_sva #(
  parameter int unsigned DATA_BITS_MAX = 10,
  parameter int unsigned DEPTH         = 8
) (
  // Clock and reset
  input wire logic                     clk_sys,
  input wire logic                     arst_n,
  // Control and line
  input wire logic                     rx_enable,
  input wire logic                     double_speed_select,
  input wire logic [3:0]               frame_bits,
  input wire logic                     sample_tick,
  input wire logic                     rxd,
  // Frames and status
  input wire logic                     frame_valid,
  input wire logic                     frame_ready,
  input wire logic [DATA_BITS_MAX-1:0] frame_data,
  input wire logic                     frame_error_flag,
  input wire logic                     rx_busy,
  input wire logic                     overrun
);
  // Beyond any frame length, assuming a tick every third clock
  localparam int IDLE_LIM = 700;
  logic [9:0] hi_q;
  logic [9:0] hi_d;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // Cycles the line stayed high, saturating
  always_comb begin
    hi_d = 10'h0;
    if (rxd) hi_d = (hi_q == 10'h3ff) ? hi_q : hi_q + 10'h1;
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) hi_q <= 10'h0;
    else hi_q <= hi_d;
  end
  a_idle_on_disable: assert property (!rx_enable [*2] |=> !rx_busy)
    else $error("busy while disabled");
  a_flush_on_disable: assert property (!rx_enable [*2] |=> !frame_valid)
    else $error("buffer not flushed");
  a_entry_holds: assert property (frame_valid && !frame_ready && rx_enable |=>
    frame_valid && $stable(frame_data) && $stable(frame_error_flag))
    else $error("entry changed before pop");
  a_gap_after_pop: assert property (frame_valid && frame_ready |=> !frame_valid)
    else $error("no gap after pop");
  a_push_on_tick: assert property ($rose(frame_valid) && !$past(frame_valid, 2) |->
    $past(sample_tick) || $past(sample_tick, 2))
    else $error("frame without tick");
  a_idle_line_rest: assert property (hi_q >= IDLE_LIM |-> !rx_busy)
    else $error("busy on idle line");
  a_overrun_full: assert property ($rose(overrun) |-> frame_valid)
    else $error("overrun with room");
  a_overrun_pop: assert property (overrun && frame_valid && frame_ready |-> ##[1:2] !overrun)
    else $error("overrun not cleared");
endmodule : acr_sva

bind acr_rx acr_sva #(.DATA_BITS_MAX(DATA_BITS_MAX), .DEPTH(DEPTH)) u_sva (
  .clk_sys(clk_sys), .arst_n(arst_n), .rx_enable(rx_enable),
  .double_speed_select(double_speed_select), .frame_bits(frame_bits),
  .sample_tick(sample_tick), .rxd(rxd), .frame_valid(frame_valid),
  .frame_ready(frame_ready), .frame_data(frame_data),
  .frame_error_flag(frame_error_flag), .rx_busy(rx_busy), .overrun(overrun));

// >>> testbench/acr_tx_model.sv
`timescale 1ns/10ps
// Remote transmitter; line idles high, one sample slot is 3 clocks
module acr_tx_model (
  // Clock
  input  wire logic clk_sys,
  // Line
  output logic      rxd
);
  initial rxd = 1'b1;
  // One frame at exact rate, so no rate error on this side
  task automatic send(input logic [9:0] d, input int n, input int s,
                      input logic stp, input int ns, input logic gl);
    logic v;
    for (int i = 0; i < n + 1 + ns; i++) begin
      v = (i == 0) ? 1'b0 : (i <= n) ? d[i-1] : (i == n + 1) ? stp : 1'b1;
      for (int j = 0; j < s; j++) begin
        @(posedge clk_sys);
        // Optional one-slot glitch on the centre sample
        rxd <= (gl && j == s / 2 && i > 0 && i <= n) ? ~v : v;
        repeat (2) @(posedge clk_sys);
      end
    end
    @(posedge clk_sys);
    rxd <= 1'b1;
  endtask : send
  // Short low pulse, too brief for a start bit
  task automatic spike(input int c);
    @(posedge clk_sys);
    rxd <= 1'b0;
    repeat (c) @(posedge clk_sys);
    rxd <= 1'b1;
  endtask : spike
endmodule : acr_tx_model

// >>> testbench/acr_rx_tb_top.sv
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; $display("unexpected at %0t: got %h", $time, a); end end
// Receiver bench
module acr_rx_tb_top;
  logic       clk_sys, arst_n, rx_enable, double_speed_select, sample_tick, frame_ready, rxd, run;
  logic       frame_valid, frame_error_flag, rx_busy, overrun;
  logic [3:0] frame_bits;
  logic [9:0] frame_data;
  logic [1:0] tick_cnt = 2'h0;
  int         n_mismatch, comparisons;
  acr_rx uut (.clk_sys(clk_sys), .arst_n(arst_n), .rx_enable(rx_enable),
    .double_speed_select(double_speed_select), .frame_bits(frame_bits), .sample_tick(sample_tick),
    .rxd(rxd), .frame_valid(frame_valid), .frame_ready(frame_ready), .frame_data(frame_data),
    .frame_error_flag(frame_error_flag), .rx_busy(rx_busy), .overrun(overrun));
  acr_tx_model tx (.clk_sys(clk_sys), .rxd(rxd));
  // 200 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Oversample tick every third clock
  always @(posedge clk_sys) begin
    tick_cnt <= (tick_cnt == 2'h2) ? 2'h0 : tick_cnt + 2'h1;
    sample_tick <= run && tick_cnt == 2'h2;
  end
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  // Wait for an entry, compare it, pop it
  task automatic pop(input logic [10:0] e);
    int k;
    k = 0;
    @(negedge clk_sys);
    while (frame_valid !== 1'b1 && k < 2000) begin
      @(negedge clk_sys);
      k++;
    end
    `CHK({frame_error_flag, frame_data}, e)
    @(posedge clk_sys);
    frame_ready <= 1'b1;
    @(posedge clk_sys);
    frame_ready <= 1'b0;
    @(posedge clk_sys);
  endtask : pop
  // Both speeds, clean and glitched centre sample
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      double_speed_select <= m[0];
      tx.send(10'h0a5 ^ 10'(m), 8, m[0] ? 8 : 16, 1'b1, 1, m[1]);
      pop({1'b0, 10'h0a5 ^ 10'(m)});
    end
    double_speed_select <= 1'b0;
  endtask : t_modes
  // Every data length, upper bits zero
  task automatic t_lengths();
    for (int n = 5; n <= 10; n++) begin
      frame_bits <= 4'(n);
      tx.send(10'h2b5, n, 16, 1'b1, 1, 1'b0);
      pop({1'b0, 10'h2b5 & ((10'h1 << n) - 10'h1)});
    end
    frame_bits <= 4'h8;
  endtask : t_lengths
  // Low stop bit, then two stop bits
  task automatic t_ferr();
    tx.send(10'h0e7, 8, 16, 1'b0, 1, 1'b0);
    pop({1'b1, 10'h0e7});
    tx.send(10'h018, 8, 16, 1'b1, 2, 1'b0);
    pop({1'b0, 10'h018});
  endtask : t_ferr
  // Spike rejected, next frame clean
  task automatic t_noise();
    tx.spike(6);
    repeat (300) @(posedge clk_sys);
    `CHK(frame_valid, 1'b0)
    tx.send(10'h03c, 8, 16, 1'b1, 1, 1'b0);
    pop({1'b0, 10'h03c});
  endtask : t_noise
  // Nine back-to-back frames into eight places
  task automatic t_full();
    for (int i = 0; i < 9; i++) tx.send(10'(i + 16), 8, 16, 1'b1, 1, 1'b0);
    `CHK(overrun, 1'b1)
    for (int i = 0; i < 8; i++) pop({1'b0, 10'(i + 16)});
    repeat (3) @(posedge clk_sys);
    `CHK(frame_valid, 1'b0)
  endtask : t_full
  // Disable mid-frame flushes and idles
  task automatic t_disable();
    tx.send(10'h055, 8, 16, 1'b1, 1, 1'b0);
    fork
      tx.send(10'h00f, 8, 16, 1'b1, 1, 1'b0);
    join_none
    repeat (200) @(posedge clk_sys);
    `CHK(rx_busy, 1'b1)
    rx_enable <= 1'b0;
    repeat (3) @(posedge clk_sys);
    `CHK({rx_busy, frame_valid}, 2'b00)
    wait fork;
    rx_enable <= 1'b1;
    tx.send(10'h033, 8, 16, 1'b1, 1, 1'b0);
    pop({1'b0, 10'h033});
  endtask : t_disable
  // Hang guard, well beyond the expected run
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_mismatch++;
    conclude();
  end
  // Reset, then scenarios
  initial begin
    n_mismatch = 0;
    comparisons = 0;
    {arst_n, rx_enable, double_speed_select, frame_ready, run} = 5'h0;
    frame_bits = 4'h8;
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    rx_enable <= 1'b1;
    repeat (3) @(posedge clk_sys);
    run <= 1'b1;
    t_modes();
    t_lengths();
    t_ferr();
    t_noise();
    t_full();
    t_disable();
    conclude();
  end
endmodule : acr_rx_tb_top
